// File: src/ivp_regs.svh
// register indices, field reset values, type tables and timing counts of the interrupt controller
// Contract
// [R1] vector address is four times type
// [R2] exceptions own types 00h to 07h
// [R3] timers types 08h,12h,13h share end type 08
// [R4] serial port 1 is type 11h
// [R5] serial 0 14h, dma 0Ah/0Bh, pins 0Ch-10h
// [R6] trace beats nmi; timer0 beats timer1 beats timer2
// [R7] slave mode types of timers, dma programmable
// [R8] grant needs enable, clear mask, top priority
// [R9] granted type selects the vector
// [R10] level pin held until service entered
// [R11] fully nested mode drives no acknowledge
// [R12] internal type needs no bus cycle
// [R13] cascade runs two acknowledge cycles, reads low byte
// [R14] bit 3 set masks the source
// [R15] bits 2-0 priority, 0 highest, 7 lowest
// [R16] edge latch holds rising edge until serviced
// [R17] bit 4 level high, else rising edge
// [R18] pins 0,1 bit 6 special nested mode
// [R19] pins 0,1 bit 5 cascade mode
// [R20] slave: pin1/pin0 registers control timer2/timer1
// [R21] master and slave expose different register sets
// [R22] mode control bit 14 selects slave
// [R23] take sets in-service, end-of-interrupt write clears
// [R24] equal priority ties go to lower type
`ifndef IVP_REGS_SVH
`define IVP_REGS_SVH
// register indices; byte address is four times the index
`define IVP_IDX_SLV_BASE   8'h20
`define IVP_IDX_END_OF_INT 8'h22
`define IVP_IDX_IN_SERVICE 8'h2c
`define IVP_IDX_CTL_BASE   8'h32
`define IVP_IDX_CTL_LAST   8'h44
`define IVP_IDX_SLV_LAST   8'h3a
`define IVP_IDX_MODE       8'hfe
`define IVP_MODE_SLAVE_BIT 14
`define IVP_NUM_CTL        10
`define IVP_NUM_SRC        12
`define IVP_NUM_EXC        8
`define IVP_CTL_RST_MASTER 8'h0f
`define IVP_CTL_RST_SLAVE  8'h00
`define IVP_WMASK_BASIC    8'h0f
`define IVP_WMASK_PIN      8'h9f
`define IVP_WMASK_PIN01    8'hff
// source order follows the type table, so a lower index is a lower type
`define IVP_MASTER_TYPES {8'h14, 8'h13, 8'h12, 8'h11, 8'h10, 8'h0f, 8'h0e, 8'h0d, 8'h0c, 8'h0b, 8'h0a, 8'h08}
`define IVP_SLAVE_CODES  {3'h0, 3'h5, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h2, 3'h0}
`define IVP_SLAVE_SRCS   12'h607
`define IVP_TYPE_TIMER_END 8'h08
`define IVP_TYPE_TRACE     8'h01
`define IVP_LVL_NONE       4'h8
`define IVP_CLK_PERIOD_NS  40
`define IVP_ACK_LOW_NS     80
`define IVP_ACK_CYC ((`IVP_ACK_LOW_NS + `IVP_CLK_PERIOD_NS - 1) / `IVP_CLK_PERIOD_NS)
`endif

// File: src/ivp_pkg.sv
// types shared by the interrupt controller
package ivp_pkg;
  // layout matches bits 7..0 of a source control register
  typedef struct packed {
    logic       edge_latch_enable;
    logic       special_nested_select;
    logic       cascade_select;
    logic       level_trigger_select;
    logic       source_mask;
    logic [2:0] priority_level;
  } ivp_ctl_t;

  typedef struct packed {
    logic [7:0] type_num;
    logic [9:0] vector_addr;
  } ivp_grant_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ACK1, ST_GAP, ST_ACK2} ivp_ack_st_t;
endpackage

// File: src/ivp_ctrl.sv
// interrupt controller: source latches, priority resolution, acknowledge and apb registers
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`include "ivp_regs.svh"
module ivp_ctrl (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [11:0]        i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic      [31:0]        o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  input  wire logic [7:0]         i_exc_req,
  input  wire logic [2:0]         i_timer_req,
  input  wire logic [1:0]         i_dma_req,
  input  wire logic [1:0]         i_serial_req,
  input  wire logic [4:0]         i_ext_pin,
  input  wire logic               i_if_flag,
  input  wire logic               i_cpu_ack,
  input  wire logic [7:0]         i_muxed_bus_low_byte,
  output logic                    o_irq_req,
  output logic                    o_inta_n,
  output logic                    o_grant_valid,
  output ivp_pkg::ivp_grant_t     o_grant
);
  localparam int ACK_CYC = `IVP_ACK_CYC;
  localparam logic [95:0] MTYPES = `IVP_MASTER_TYPES;
  localparam logic [35:0] SCODES = `IVP_SLAVE_CODES;

  ivp_pkg::ivp_ctl_t    ctl_ff [`IVP_NUM_CTL];
  ivp_pkg::ivp_ctl_t    ctl_of [`IVP_NUM_SRC];
  ivp_pkg::ivp_ack_st_t st_ff;
  ivp_pkg::ivp_ack_st_t nxt_st;
  logic [7:0]  type_of [`IVP_NUM_SRC];
  logic        slave_ff;
  logic [4:0]  slv_base_ff;
  logic [11:0] in_service_bits_ff;
  logic [7:0]  exc_pend_ff;
  logic [11:0] pend;
  logic [11:0] elig;
  logic [11:0] active;
  logic [11:0] take_src;
  logic [11:0] int_req;
  logic [11:0] end_clr;
  logic [4:0]  pin_s1_ff;
  logic [4:0]  pin_s2_ff;
  logic [4:0]  pin_d_ff;
  logic [4:0]  pin_rise;
  logic [7:0]  bus_s1_ff;
  logic [7:0]  bus_s2_ff;
  logic [3:0]  isr_min;
  logic [3:0]  best_idx;
  logic [3:0]  best_lvl;
  logic        found;
  logic        exc_hit;
  logic [2:0]  exc_sel;
  logic        take;
  logic        take_casc;
  logic [7:0]  take_type;
  logic [7:0]  held_type_ff;
  logic [1:0]  cnt_ff;
  logic        cnt_last;
  logic [1:0]  casc_wait_ff;
  logic [7:0]  idx;
  logic        hit;
  logic [31:0] rd_data;
  logic        wr_en;
  logic [15:0] in_service_view;

  // pins come from outside the clock domain; two flops before any logic
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_ff <= 5'h00;
      pin_s2_ff <= 5'h00;
      pin_d_ff  <= 5'h00;
      bus_s1_ff <= 8'h00;
      bus_s2_ff <= 8'h00;
    end else begin
      pin_s1_ff <= i_ext_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_d_ff  <= pin_s2_ff;
      bus_s1_ff <= i_muxed_bus_low_byte;
      bus_s2_ff <= bus_s1_ff;
    end
  end
  assign pin_rise = pin_s2_ff & ~pin_d_ff;

  assign int_req = {i_serial_req[0], i_timer_req[2], i_timer_req[1], i_serial_req[1],
                    5'h00, i_dma_req[1], i_dma_req[0], i_timer_req[0]};
  assign active  = slave_ff ? `IVP_SLAVE_SRCS : 12'hfff;

  // per-source control view, type and pending state
  for (genvar gi = 0; gi < `IVP_NUM_SRC; gi++) begin : g_src
    localparam int RM = (gi == 0 || gi == 9 || gi == 10) ? 0 : (gi == 11) ? 9 : gi;
    localparam int RS = (gi == 9) ? 3 : (gi == 10) ? 4 : RM;
    assign ctl_of[gi] = slave_ff ? ctl_ff[RS] : ctl_ff[RM]; // [R20]
    assign type_of[gi] = slave_ff ? {slv_base_ff, SCODES[3*gi +: 3]} // [R7]
                                  : MTYPES[8*gi +: 8]; // [R3] [R4] [R5]
    if (gi >= 3 && gi <= 7) begin : g_pin
      logic lat_ff;
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          lat_ff <= 1'b0;
        end else begin
          // a new edge in the take cycle survives the clear
          lat_ff <= (lat_ff & ~take_src[gi]) | (pin_rise[gi-3] // [R16]
                    & ctl_of[gi].edge_latch_enable & ~ctl_of[gi].level_trigger_select);
        end
      end
      // level mode relies on the pin staying high until service starts
      assign pend[gi] = ctl_of[gi].level_trigger_select ? pin_s2_ff[gi-3] // [R17] [R10]
                      : (lat_ff | (pin_rise[gi-3] & ~ctl_of[gi].edge_latch_enable));
    end else begin : g_int
      logic req_ff;
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          req_ff <= 1'b0;
        end else begin
          req_ff <= (req_ff & ~take_src[gi]) | int_req[gi];
        end
      end
      assign pend[gi] = req_ff;
    end
    // special nested lets pins 0 and 1 re-enter at their own level
    assign elig[gi] = pend[gi] & active[gi] & i_if_flag & ~ctl_of[gi].source_mask // [R8] [R14]
                    & (({1'b0, ctl_of[gi].priority_level} < isr_min)
                    | ((gi == 3 || gi == 4) & ~slave_ff & ctl_of[gi].special_nested_select // [R18]
                       & ({1'b0, ctl_of[gi].priority_level} <= isr_min)));
    assign take_src[gi] = take & ~exc_hit & (best_idx == 4'(gi));
    assign end_clr[gi] = wr_en & (idx == `IVP_IDX_END_OF_INT)
                       & ((i_pwdata[7:0] == type_of[gi])
                       | (~slave_ff & (gi == 9 || gi == 10)
                          & (i_pwdata[7:0] == `IVP_TYPE_TIMER_END))); // [R3]
  end

  // highest priority among sources already in service
  always_comb begin
    isr_min = `IVP_LVL_NONE;
    for (int i = 0; i < `IVP_NUM_SRC; i++) begin
      if (in_service_bits_ff[i] && ({1'b0, ctl_of[i].priority_level} < isr_min)) begin
        isr_min = {1'b0, ctl_of[i].priority_level};
      end
    end
  end

  // lowest level wins; scanning down with <= leaves the lowest type on a tie
  always_comb begin
    best_idx = 4'h0;
    best_lvl = `IVP_LVL_NONE;
    found    = 1'b0;
    for (int i = `IVP_NUM_SRC - 1; i >= 0; i--) begin
      if (elig[i] && ({1'b0, ctl_of[i].priority_level} <= best_lvl)) begin // [R15] [R24] [R6]
        best_idx = 4'(i);
        best_lvl = {1'b0, ctl_of[i].priority_level};
        found    = 1'b1;
      end
    end
  end

  // exceptions are never masked; lowest type first puts trace ahead of nmi
  always_comb begin
    exc_sel = 3'h0;
    for (int i = `IVP_NUM_EXC - 1; i >= 0; i--) begin
      if (exc_pend_ff[i]) begin
        exc_sel = 3'(i); // [R2] [R6]
      end
    end
  end
  assign exc_hit = |exc_pend_ff;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      exc_pend_ff <= 8'h00;
    end else begin
      exc_pend_ff <= (exc_pend_ff & ~((take & exc_hit) ? (8'h01 << exc_sel) : 8'h00)) | i_exc_req;
    end
  end

  assign take      = i_cpu_ack & o_irq_req & (st_ff == ivp_pkg::ST_IDLE) & (exc_hit | found);
  assign take_type = exc_hit ? {5'h00, exc_sel} : type_of[best_idx]; // [R9]
  assign take_casc = ~exc_hit & ~slave_ff & (best_idx == 4'd3 || best_idx == 4'd4)
                   & ctl_of[best_idx].cascade_select; // [R19]

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_service_bits_ff <= 12'h000;
    end else begin
      in_service_bits_ff <= (in_service_bits_ff & ~end_clr) | take_src; // [R23]
    end
  end

  // acknowledge sequencer; only cascade takes leave idle
  assign cnt_last = (cnt_ff == 2'(ACK_CYC - 1));
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ivp_pkg::ST_IDLE: if (take && take_casc) nxt_st = ivp_pkg::ST_ACK1; // [R13]
      ivp_pkg::ST_ACK1: if (cnt_last) nxt_st = ivp_pkg::ST_GAP;
      ivp_pkg::ST_GAP:  if (cnt_last) nxt_st = ivp_pkg::ST_ACK2;
      ivp_pkg::ST_ACK2: if (cnt_last) nxt_st = ivp_pkg::ST_IDLE;
      default:          nxt_st = ivp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff        <= ivp_pkg::ST_IDLE;
      cnt_ff       <= 2'h0;
      casc_wait_ff <= 2'h0;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= (nxt_st != st_ff) ? 2'h0 : cnt_ff + 2'h1;
      // bus byte of the second cycle needs two more edges through the synchroniser
      casc_wait_ff <= {casc_wait_ff[0], (st_ff == ivp_pkg::ST_ACK2) & cnt_last}; // [R13]
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_inta_n     <= 1'b1;
      held_type_ff <= 8'h00;
    end else begin
      // low only inside cascade cycles; nested mode never pulses it
      o_inta_n <= ~(nxt_st == ivp_pkg::ST_ACK1 || nxt_st == ivp_pkg::ST_ACK2); // [R11] [R13]
      if (take) begin
        held_type_ff <= take_type;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_grant_valid <= 1'b0;
      o_grant       <= '0;
    end else begin
      o_grant_valid <= 1'b0;
      if (take && !take_casc) begin
        o_grant_valid <= 1'b1; // [R12]
        o_grant       <= {take_type, take_type, 2'b00}; // [R1]
      end else if (casc_wait_ff[1]) begin
        // type driven in the second cycle, two synchroniser flops later
        o_grant_valid <= 1'b1; // [R13]
        o_grant       <= {bus_s2_ff, bus_s2_ff, 2'b00}; // [R1]
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_req <= 1'b0;
    end else begin
      o_irq_req <= (exc_hit | found) & (nxt_st == ivp_pkg::ST_IDLE) & ~take // [R8]
                   & ~((st_ff == ivp_pkg::ST_ACK2) & cnt_last) & ~casc_wait_ff[0];
    end
  end

  // apb slave: decode in setup, answer with one wait-free access cycle
  assign idx   = i_paddr[9:2];
  assign wr_en = i_psel & i_penable & o_pready & i_pwrite & hit;

  always_comb begin
    in_service_view = 16'h0000;
    if (slave_ff) begin
      in_service_view[0]   = in_service_bits_ff[0];
      in_service_view[3:2] = in_service_bits_ff[2:1];
      in_service_view[5:4] = in_service_bits_ff[10:9];
    end else begin
      in_service_view[0]   = |{in_service_bits_ff[10:9], in_service_bits_ff[0]};
      in_service_view[3:2] = in_service_bits_ff[2:1];
      in_service_view[8:4] = in_service_bits_ff[7:3];
      in_service_view[9]   = in_service_bits_ff[8];
      in_service_view[10]  = in_service_bits_ff[11];
    end
  end

  always_comb begin
    hit     = 1'b0;
    rd_data = 32'h0000_0000;
    if (i_paddr[11:10] == 2'b00 && i_paddr[1:0] == 2'b00) begin
      if (idx == `IVP_IDX_MODE) begin // [R22]
        hit = 1'b1;
        rd_data[`IVP_MODE_SLAVE_BIT] = slave_ff;
      end else if (idx == `IVP_IDX_IN_SERVICE) begin
        hit     = 1'b1;
        rd_data = {16'h0000, in_service_view};
      end else if (idx == `IVP_IDX_END_OF_INT) begin
        hit = 1'b1;
      end else if (idx == `IVP_IDX_SLV_BASE) begin
        hit     = slave_ff;
        rd_data = slave_ff ? {24'h0, slv_base_ff, 3'h0} : 32'h0;
      end else if (idx >= `IVP_IDX_CTL_BASE && !idx[0]
                   && idx <= (slave_ff ? `IVP_IDX_SLV_LAST : `IVP_IDX_CTL_LAST)) begin // [R21]
        hit     = 1'b1;
        rd_data = {24'h0, ctl_ff[4'((idx - `IVP_IDX_CTL_BASE) >> 1)]};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~hit;
      o_prdata  <= (i_psel & ~i_penable & ~i_pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // a mode change reloads every control register with that mode's reset value
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slave_ff    <= 1'b0;
      slv_base_ff <= 5'h00;
      for (int r = 0; r < `IVP_NUM_CTL; r++) begin
        ctl_ff[r] <= `IVP_CTL_RST_MASTER;
      end
    end else if (wr_en && idx == `IVP_IDX_MODE) begin
      slave_ff <= i_pwdata[`IVP_MODE_SLAVE_BIT]; // [R22]
      if (i_pwdata[`IVP_MODE_SLAVE_BIT] != slave_ff) begin
        for (int r = 0; r < `IVP_NUM_CTL; r++) begin
          ctl_ff[r] <= i_pwdata[`IVP_MODE_SLAVE_BIT] ? `IVP_CTL_RST_SLAVE // [R20]
                                                      : `IVP_CTL_RST_MASTER;
        end
      end
    end else if (wr_en && idx == `IVP_IDX_SLV_BASE) begin
      slv_base_ff <= i_pwdata[7:3]; // [R7]
    end else if (wr_en && idx >= `IVP_IDX_CTL_BASE) begin
      for (int r = 0; r < `IVP_NUM_CTL; r++) begin
        if (idx == `IVP_IDX_CTL_BASE + 8'(2 * r)) begin
          // reserved bits stay zero; mode bits exist on the pin registers only
          ctl_ff[r] <= i_pwdata[7:0] & ((slave_ff || r < 3 || r > 7) ? `IVP_WMASK_BASIC
                       : (r < 5) ? `IVP_WMASK_PIN01 : `IVP_WMASK_PIN); // [R14] [R15] [R18]
        end
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_ack_low;
    !o_inta_n [*2];
  endsequence
  sequence s_ack_gap;
    o_inta_n [*2];
  endsequence

  a_vector_addr: assert property (o_grant_valid |-> // [R1]
    o_grant.vector_addr == {o_grant.type_num, 2'b00}) else $error("vector not four times type");
  a_casc_two_acks: assert property (take && take_casc |=> // [R13]
    s_ack_low ##1 s_ack_gap ##1 s_ack_low
    ##3 (o_grant_valid && o_grant.type_num == $past(bus_s2_ff)))
    else $error("cascade acknowledge sequence wrong");
  a_internal_type: assert property (take && !take_casc |=> // [R12]
    o_grant_valid && o_inta_n && o_grant.type_num == $past(take_type))
    else $error("internal type not delivered next cycle");
  a_nested_no_ack: assert property (st_ff == ivp_pkg::ST_IDLE && !(take && take_casc) |=> // [R11]
    o_inta_n) else $error("acknowledge driven outside cascade");
  a_grant_allowed: assert property (take && !exc_hit |-> i_if_flag // [R8]
    && !ctl_of[best_idx].source_mask) else $error("masked source granted");
  a_trace_over_nmi: assert property (take && exc_pend_ff[2:0] == 3'b110 |=> // [R6]
    o_grant_valid && o_grant.type_num == `IVP_TYPE_TRACE) else $error("nmi beat trace");
  a_tie_lower_type: assert property (found && elig[0] && elig[9] // [R24]
    && ctl_of[0].priority_level == ctl_of[9].priority_level |-> best_idx != 4'd9)
    else $error("tie not resolved by type");
  a_service_set: assert property (take && !exc_hit |=> // [R23]
    in_service_bits_ff[$past(best_idx)]) else $error("in-service bit not set");
  a_edge_latch: assert property (pin_rise[2] && ctl_of[5].edge_latch_enable // [R16]
    && !ctl_of[5].level_trigger_select && !take_src[5] |=> pend[5]) else $error("edge lost");
  a_apb_answer: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
    else $error("apb answer timing");
endmodule // ivp_ctrl

// File: test/ivp_ext_model.sv
// behavioural model of the external pins and the cascaded controller
`timescale 1ns/1ps
module ivp_ext_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_inta_n,
  input  wire logic [4:0] i_pin_cmd,
  input  wire logic [7:0] i_type,
  output logic      [4:0] o_ext_pin,
  output logic      [7:0] o_bus
);
  logic       inta_d_ff;
  logic       odd_ff;
  logic       drv_ff;
  logic [1:0] hold_ff;
  logic [7:0] last_ff;
  // pins follow the bench, which holds a level request until service is entered
  assign o_ext_pin = i_pin_cmd;
  // released bus toggles so a stale type is never mistaken for a fresh one
  // type only from the start of the second acknowledge on
  assign o_bus = (drv_ff || (odd_ff && inta_d_ff && !i_inta_n)) ? i_type : ~last_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      inta_d_ff <= 1'b1;
      odd_ff    <= 1'b0;
      drv_ff    <= 1'b0;
      hold_ff   <= 2'h0;
      last_ff   <= 8'h00;
    end else begin
      inta_d_ff <= i_inta_n;
      last_ff   <= o_bus;
      if (inta_d_ff && !i_inta_n) begin
        odd_ff <= !odd_ff;
        drv_ff <= odd_ff;
      end else if (drv_ff && i_inta_n) begin
        // short hold after the second acknowledge covers the design's synchroniser
        hold_ff <= (hold_ff == 2'h2) ? 2'h0 : hold_ff + 2'h1;
        drv_ff  <= (hold_ff != 2'h2);
      end
    end
  end
endmodule // ivp_ext_model

// File: test/interrupt_vector_priority_control_tb.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module interrupt_vector_priority_control_tb;
  logic                i_clk = 1'b0;
  logic                i_rst_n = 1'b0;
  logic                i_psel = 1'b0;
  logic                i_penable = 1'b0;
  logic                i_pwrite = 1'b0;
  logic                i_if_flag = 1'b1;
  logic                i_cpu_ack = 1'b0;
  logic [11:0]         i_paddr = 12'h000;
  logic [31:0]         i_pwdata = 32'h0;
  logic [7:0]          i_exc_req = 8'h00;
  logic [2:0]          i_timer_req = 3'h0;
  logic [1:0]          i_dma_req = 2'h0;
  logic [1:0]          i_serial_req = 2'h0;
  logic [4:0]          pin_cmd = 5'h00;
  logic [7:0]          cas_type = 8'h00;
  logic [31:0]         o_prdata;
  logic                o_pready, o_pslverr, o_irq_req, o_inta_n, o_grant_valid, inta_q;
  logic [4:0]          ext_pin;
  logic [7:0]          bus;
  ivp_pkg::ivp_grant_t o_grant;
  ivp_pkg::ivp_grant_t gq[$];
  logic [32:0]         rq[$];
  int                  bad_count = 0;
  int                  samples_checked = 0;
  int                  acks = 0;
  integer              seed = 32'hcedb;

  always #20 i_clk = ~i_clk;

  ivp_ctrl uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_exc_req(i_exc_req),
    .i_timer_req(i_timer_req), .i_dma_req(i_dma_req), .i_serial_req(i_serial_req),
    .i_ext_pin(ext_pin), .i_if_flag(i_if_flag), .i_cpu_ack(i_cpu_ack),
    .i_muxed_bus_low_byte(bus), .o_irq_req(o_irq_req), .o_inta_n(o_inta_n),
    .o_grant_valid(o_grant_valid), .o_grant(o_grant));

  ivp_ext_model far (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_inta_n(o_inta_n),
    .i_pin_cmd(pin_cmd), .i_type(cas_type), .o_ext_pin(ext_pin), .o_bus(bus));

  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic to_fail(input string m);
    chk(1'b0, m);
    complete_run();
  endtask

  // read expectations carry {pslverr, prdata}
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    if (!w) rq.push_back(e);
    @(posedge i_clk);
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge i_clk);
      if (o_pready === 1'b1) break;
    end
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    if (n == 20) to_fail("no pready");
  endtask

  task automatic pulse(input logic [7:0] e, input logic [2:0] t, input logic [1:0] d,
                       input logic [1:0] s);
    @(posedge i_clk);
    {i_exc_req, i_timer_req, i_dma_req, i_serial_req} <= {e, t, d, s};
    @(posedge i_clk);
    {i_exc_req, i_timer_req, i_dma_req, i_serial_req} <= 15'h0;
  endtask

  task automatic ack(input logic [7:0] t);
    int n;
    for (n = 0; n < 40 && o_irq_req !== 1'b1; n++) @(posedge i_clk);
    if (n == 40) to_fail("no request");
    gq.push_back({t, t, 2'b00});
    i_cpu_ack <= 1'b1;
    @(posedge i_clk);
    i_cpu_ack <= 1'b0;
    for (n = 0; n < 20 && gq.size() != 0; n++) @(posedge i_clk);
    if (n == 20) to_fail("no grant");
    repeat (2) @(posedge i_clk);
  endtask

  task automatic quiet(input int c);
    repeat (c) begin
      @(posedge i_clk);
      chk(o_irq_req === 1'b0, "unexpected request");
    end
  endtask

  always @(posedge i_clk) begin
    if (o_pready === 1'b1 && i_pwrite === 1'b0) begin
      if (rq.size() == 0) chk(1'b0, "extra read");
      else chk({o_pslverr, o_prdata} === rq.pop_front(), "read data");
    end
    if (o_grant_valid === 1'b1) begin
      if (gq.size() == 0) chk(1'b0, "extra grant");
      else chk(o_grant === gq.pop_front(), "grant type or vector");
    end
    if (inta_q === 1'b1 && o_inta_n === 1'b0) acks++;
    inta_q <= o_inta_n;
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    to_fail("run too long");
  end

  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    apb(1'b0, 12'h0c8, 32'h0, 33'h00000000f);
    apb(1'b0, 12'h0b0, 32'h0, 33'h0);
    apb(1'b0, 12'h080, 32'h0, {1'b1, 32'h0});
    apb(1'b0, 12'h004, 32'h0, {1'b1, 32'h0});
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i, 3'h0, 2'h0, 2'h0);
      ack(i[7:0]);
    end
    pulse(8'h06, 3'h0, 2'h0, 2'h0);
    ack(8'h01);
    ack(8'h02);
    $display("test exceptions done");
    apb(1'b1, 12'h0c8, 32'h0, 33'h0);
    pulse(8'h00, 3'h7, 2'h0, 2'h0);
    ack(8'h08);
    apb(1'b0, 12'h0b0, 32'h0, 33'h1);
    apb(1'b1, 12'h088, 32'h08, 33'h0);
    ack(8'h12);
    apb(1'b1, 12'h088, 32'h08, 33'h0);
    ack(8'h13);
    apb(1'b1, 12'h088, 32'h08, 33'h0);
    apb(1'b0, 12'h0b0, 32'h0, 33'h0);
    $display("test timers done");
    i_if_flag <= 1'b0;
    apb(1'b1, 12'h108, 32'h0, 33'h0);
    pulse(8'h00, 3'h0, 2'h0, 2'h2);
    quiet(6);
    i_if_flag <= 1'b1;
    ack(8'h11);
    apb(1'b1, 12'h088, 32'h11, 33'h0);
    pulse(8'h00, 3'h0, 2'h0, 2'h1);
    quiet(6);
    apb(1'b1, 12'h110, 32'h1, 33'h0);
    apb(1'b1, 12'h0d0, 32'h2, 33'h0);
    apb(1'b1, 12'h0d8, 32'h2, 33'h0);
    pulse(8'h00, 3'h0, 2'h3, 2'h1);
    ack(8'h14);
    apb(1'b1, 12'h088, 32'h14, 33'h0);
    ack(8'h0a);
    apb(1'b1, 12'h088, 32'h0a, 33'h0);
    ack(8'h0b);
    apb(1'b1, 12'h088, 32'h0b, 33'h0);
    $display("test serial and dma done");
    apb(1'b1, 12'h0f0, 32'h80, 33'h0);
    pin_cmd <= 5'h04;
    repeat (3) @(posedge i_clk);
    pin_cmd <= 5'h00;
    ack(8'h0e);
    apb(1'b1, 12'h088, 32'h0e, 33'h0);
    quiet(6);
    apb(1'b1, 12'h0f8, 32'h10, 33'h0);
    pin_cmd <= 5'h08;
    ack(8'h0f);
    pin_cmd <= 5'h00;
    apb(1'b1, 12'h088, 32'h0f, 33'h0);
    // special nested pin re-enters at its own level while still in service
    apb(1'b1, 12'h0e8, 32'h50, 33'h0);
    pin_cmd <= 5'h02;
    ack(8'h0d);
    ack(8'h0d);
    pin_cmd <= 5'h00;
    apb(1'b1, 12'h088, 32'h0d, 33'h0);
    $display("test pins done");
    cas_type <= 8'($random(seed));
    apb(1'b1, 12'h0e0, 32'h30, 33'h0);
    pin_cmd <= 5'h01;
    ack(cas_type);
    pin_cmd <= 5'h00;
    apb(1'b1, 12'h088, 32'h0c, 33'h0);
    chk(acks == 2, "acknowledge cycle count");
    $display("test cascade done");
    apb(1'b1, 12'h3f8, 32'h4000, 33'h0);
    apb(1'b0, 12'h3f8, 32'h0, 33'h000004000);
    apb(1'b0, 12'h0e0, 32'h0, 33'h0);
    apb(1'b0, 12'h110, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h080, 32'h40, 33'h0);
    pulse(8'h00, 3'h2, 2'h0, 2'h0);
    ack(8'h44);
    $display("test slave done");
    complete_run();
  end
endmodule // interrupt_vector_priority_control_tb
